/* hw/seek_consts.vh */
`ifndef SEEK_CONSTS_VH
`define SEEK_CONSTS_VH

// Register word addresses on the plain register port.
`define REG_CTRL      8'h00
`define REG_CMD       8'h04
`define REG_CFG_MODE  8'h08
`define REG_CFG_FAST  8'h0c
`define REG_CFG_SLOW  8'h10
`define REG_CFG_ZCNT  8'h14
`define REG_CFG_DECEL 8'h18
`define REG_STATUS    8'h20
`define REG_POS       8'h24
`define REG_SPEED     8'h28

// Field positions.
`define CTRL_ENABLE_BIT  0
`define MODE_LSB         0
`define MODE_MSB         2
`define SEEK_DIR_BIT     4
`define APPR_DIR_BIT     5
`define ST_DONE_BIT      0
`define ST_BUSY_BIT      1
`define ST_DIR_BIT       2
`define ST_ERR_LSB       8
`define ST_ERR_MSB       15

// Commands written to the command register.
`define CMD_SEEK 8'h01
`define CMD_LOAD 8'h02

// Result codes.
`define ERR_NONE    8'h00
`define ERR_ABORT   8'h01
`define ERR_SHORT   8'h02
`define ERR_LIMIT   8'h03
`define ERR_NOT_EN  8'h04
`define ERR_BAD_CMD 8'h05

// Reset values of the configuration table: mode 1, seek negative, approach positive.
`define RST_CFG_MODE  32'h0000_0021
`define RST_CFG_FAST  32'h0000_2710
`define RST_CFG_SLOW  32'h0000_03e8
`define RST_CFG_ZCNT  32'h0000_0001
`define RST_CFG_DECEL 32'h0000_0064

// Clock rate in hertz, the reference for step rates.
`define CLK_HZ 32'h0ee6_b280

`endif

/* hw/pin_sync.v */
// Two-stage synchroniser for a group of asynchronous pins.
module pin_sync #(
  parameter WIDTH = 4
) (
  // Clock and reset.
  input  wire             i_clk,
  input  wire             i_sys_rst,
  // Pins in and synchronised levels out.
  input  wire [WIDTH-1:0] i_pins,
  output reg  [WIDTH-1:0] o_levels
);

  reg [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta     <= {WIDTH{1'b0}};
      o_levels <= {WIDTH{1'b0}};
    end else begin
      meta     <= i_pins;
      o_levels <= meta;
    end
  end

endmodule // pin_sync

/* hw/step_rate.v */
`include "seek_consts.vh"

// Step enable generator: a phase accumulator gives exact average step rates up to the clock rate.
module step_rate (
  // Clock and reset.
  input  wire        i_clk,
  input  wire        i_sys_rst,
  // Rate control.
  input  wire        i_run,
  input  wire [31:0] i_speed,
  output reg         o_step
);

  reg  [32:0] acc;
  wire [32:0] sum = acc + {1'b0, i_speed};

  // Speeds at or above the clock rate saturate at one step per cycle.
  always @(posedge i_clk) begin
    if (i_sys_rst || !i_run) begin
      acc    <= 33'h0_0000_0000;
      o_step <= 1'b0;
    end else if (sum >= {1'b0, `CLK_HZ}) begin
      acc    <= (sum - {1'b0, `CLK_HZ} >= {1'b0, `CLK_HZ}) ? 33'h0_0000_0000 : sum - {1'b0, `CLK_HZ};
      o_step <= 1'b1;
    end else begin
      acc    <= sum;
      o_step <= 1'b0;
    end
  end

endmodule // step_rate

/* hw/reference_seek_motion_control.v */
`include "seek_consts.vh"

// Reference seek motion controller with register port and axis pins.
module reference_seek_motion_control (
  // Clock and reset.
  input  wire        i_clk,
  input  wire        i_sys_rst,
  // Register port.
  input  wire [7:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  // Axis pins.
  input  wire        i_reference_switch_input,
  input  wire        i_zero_pulse_input,
  input  wire        i_upper_limit_switch,
  input  wire        i_lower_limit_switch,
  output reg         o_step,
  output reg         o_dir,
  // Status outputs.
  output reg         o_done,
  output wire        o_busy,
  output reg  [7:0]  o_error,
  output reg  [31:0] o_position,
  output reg  [31:0] o_speed
);

  localparam S_IDLE    = 3'h0;
  localparam S_FAST    = 3'h1;
  localparam S_BRAKE   = 3'h2;
  localparam S_EXIT    = 3'h3;
  localparam S_APPR    = 3'h4;
  localparam S_INSIDE  = 3'h5;
  localparam S_OUTSIDE = 3'h6;
  localparam S_BACK    = 3'h7;

  // Staging table written by software, and the active copy the seek uses.
  reg [31:0] stg_mode;
  reg [31:0] stg_fast;
  reg [31:0] stg_slow;
  reg [31:0] stg_zcnt;
  reg [31:0] stg_decel;
  reg [31:0] act_mode;
  reg [31:0] act_fast;
  reg [31:0] act_slow;
  reg [31:0] act_zcnt;
  reg [31:0] act_decel;
  reg        load_pending;

  reg        module_enable;
  reg        enable_q;
  reg [2:0]  state;
  reg        reversed;
  reg        pass;
  reg [31:0] cnt;
  reg [31:0] width;
  reg [31:0] zcnt;
  reg        zp_q;

  wire [3:0] pins_s;
  wire       reference_switch_input   = pins_s[0];
  wire       zp    = pins_s[1];
  wire       lim_p = pins_s[2];
  wire       lim_n = pins_s[3];
  wire       zp_rise = zp && !zp_q;
  wire [2:0] mode     = act_mode[`MODE_MSB:`MODE_LSB];
  wire       seek_dir = act_mode[`SEEK_DIR_BIT];
  wire       appr_dir = act_mode[`APPR_DIR_BIT];
  wire       moving   = (state != S_IDLE);
  wire       at_limit = o_dir ? lim_p : lim_n;
  wire       step_en;

  // Fast speed until braking ends; slow speed while leaving the switch region and on the final approach.
  wire [31:0] cur_speed = (state == S_FAST || state == S_BRAKE) ? act_fast : act_slow;

  wire cmd_wr = i_wr && (i_addr == `REG_CMD);

  assign o_busy = moving;

  pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_pins    ({i_lower_limit_switch, i_upper_limit_switch, i_zero_pulse_input, i_reference_switch_input}),
    .o_levels  (pins_s)
  );

  step_rate u_rate (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_run     (moving),
    .i_speed   (cur_speed),
    .o_step    (step_en)
  );

  // Software-visible staging table and the enable bit.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      module_enable <= 1'b0;
      stg_mode      <= `RST_CFG_MODE;
      stg_fast      <= `RST_CFG_FAST;
      stg_slow      <= `RST_CFG_SLOW;
      stg_zcnt      <= `RST_CFG_ZCNT;
      stg_decel     <= `RST_CFG_DECEL;
    end else if (i_wr) begin
      case (i_addr)
        `REG_CTRL:      module_enable <= i_wdata[`CTRL_ENABLE_BIT];
        `REG_CFG_MODE:  stg_mode      <= i_wdata;
        `REG_CFG_FAST:  stg_fast      <= i_wdata;
        `REG_CFG_SLOW:  stg_slow      <= i_wdata;
        `REG_CFG_ZCNT:  stg_zcnt      <= i_wdata;
        `REG_CFG_DECEL: stg_decel     <= i_wdata;
        default: begin
        end
      endcase
    end
  end

  // Read data appear in the cycle after the read strobe; unmapped reads give zero.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        `REG_CTRL:      o_rdata <= {31'h0000_0000, module_enable};
        `REG_CFG_MODE:  o_rdata <= stg_mode;
        `REG_CFG_FAST:  o_rdata <= stg_fast;
        `REG_CFG_SLOW:  o_rdata <= stg_slow;
        `REG_CFG_ZCNT:  o_rdata <= stg_zcnt;
        `REG_CFG_DECEL: o_rdata <= stg_decel;
        `REG_STATUS:    o_rdata <= {16'h0000, o_error, 5'h00, o_dir, o_busy, o_done};
        `REG_POS:       o_rdata <= o_position;
        `REG_SPEED:     o_rdata <= o_speed;
        default:        o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // Active table: loaded once after each reset and then only by the load command.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      load_pending <= 1'b1;
      act_mode     <= `RST_CFG_MODE;
      act_fast     <= `RST_CFG_FAST;
      act_slow     <= `RST_CFG_SLOW;
      act_zcnt     <= `RST_CFG_ZCNT;
      act_decel    <= `RST_CFG_DECEL;
    end else begin
      load_pending <= 1'b0;
      if (load_pending || (cmd_wr && module_enable && !moving && i_wdata[7:0] == `CMD_LOAD)) begin
        act_mode  <= stg_mode;
        act_fast  <= stg_fast;
        act_slow  <= stg_slow;
        act_zcnt  <= stg_zcnt;
        act_decel <= stg_decel;
      end
    end
  end

  // Status: speed reads zero at rest; step pulses are registered.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_speed <= 32'h0000_0000;
      o_step  <= 1'b0;
      zp_q    <= 1'b0;
    end else begin
      o_speed <= moving ? cur_speed : 32'h0000_0000;
      o_step  <= step_en && moving;
      zp_q    <= zp;
    end
  end

  // Seek sequencer. The active region is approached in the approach direction from
  // outside so that modes 1 to 4 all place the point on the same mechanical side.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      state      <= S_IDLE;
      o_dir      <= 1'b0;
      o_done     <= 1'b0;
      o_error    <= `ERR_NONE;
      o_position <= 32'h0000_0000;
      enable_q   <= 1'b0;
      reversed   <= 1'b0;
      pass       <= 1'b0;
      cnt        <= 32'h0000_0000;
      width      <= 32'h0000_0000;
      zcnt       <= 32'h0000_0000;
    end else begin
      enable_q <= module_enable;
      if (moving && step_en) begin
        o_position <= o_dir ? o_position + 32'h0000_0001 : o_position - 32'h0000_0001;
      end
      if (moving && enable_q && !module_enable) begin
        state   <= S_IDLE;
        o_done  <= 1'b1;
        o_error <= `ERR_ABORT;
      end else if (!moving && cmd_wr) begin
        if (!module_enable) begin
          o_done  <= 1'b1;
          o_error <= `ERR_NOT_EN;
        end else if (i_wdata[7:0] == `CMD_LOAD) begin
          o_done  <= 1'b1;
          o_error <= `ERR_NONE;
        end else if (i_wdata[7:0] == `CMD_SEEK) begin
          o_error  <= `ERR_NONE;
          reversed <= 1'b0;
          pass     <= 1'b0;
          if (mode == 3'h0 || mode > 3'h4) begin
            o_done <= 1'b1;
          end else begin
            o_done <= 1'b0;
            state  <= S_FAST;
            o_dir  <= seek_dir;
          end
        end else begin
          o_done  <= 1'b1;
          o_error <= `ERR_BAD_CMD;
        end
      end else if (moving && at_limit && !(state == S_FAST && !reversed)) begin
        state   <= S_IDLE;
        o_done  <= 1'b1;
        o_error <= `ERR_LIMIT;
      end else begin
        case (state)
          S_FAST: begin
            if (at_limit) begin
              o_dir    <= ~o_dir;
              reversed <= 1'b1;
            end else if (reference_switch_input) begin
              state <= S_BRAKE;
              cnt   <= 32'h0000_0000;
            end
          end
          S_BRAKE: begin
            if (cnt >= act_decel) begin
              state <= S_EXIT;
              o_dir <= ~appr_dir;
            end else if (!reference_switch_input) begin
              state   <= S_IDLE;
              o_done  <= 1'b1;
              o_error <= `ERR_SHORT;
            end else if (step_en) begin
              cnt <= cnt + 32'h0000_0001;
            end
          end
          S_EXIT: begin
            if (!reference_switch_input) begin
              state <= S_APPR;
              o_dir <= appr_dir;
            end
          end
          S_APPR: begin
            if (reference_switch_input) begin
              cnt  <= 32'h0000_0000;
              zcnt <= 32'h0000_0000;
              if (mode == 3'h1) begin
                state      <= S_IDLE;
                o_done     <= 1'b1;
                o_position <= 32'h0000_0000;
              end else begin
                state <= S_INSIDE;
              end
            end
          end
          S_INSIDE: begin
            if (step_en) begin
              cnt <= cnt + 32'h0000_0001;
            end
            if (zp_rise) begin
              zcnt <= zcnt + 32'h0000_0001;
            end
            if (mode == 3'h4 && zcnt >= act_zcnt) begin
              state      <= S_IDLE;
              o_done     <= 1'b1;
              o_position <= 32'h0000_0000;
            end else if (mode == 3'h2 && pass && cnt >= {1'b0, width[31:1]}) begin
              state      <= S_IDLE;
              o_done     <= 1'b1;
              o_position <= 32'h0000_0000;
            end else if (!reference_switch_input) begin
              if (mode == 3'h3) begin
                state <= S_OUTSIDE;
                zcnt  <= 32'h0000_0000;
              end else if (mode == 3'h2 && !pass) begin
                width <= cnt;
                pass  <= 1'b1;
                state <= S_BACK; // The carriage is past the region, so it must cross it once more.
                o_dir <= ~appr_dir;
              end else begin
                state   <= S_IDLE;
                o_done  <= 1'b1;
                o_error <= `ERR_SHORT;
              end
            end
          end
          S_OUTSIDE: begin
            if (zcnt >= act_zcnt) begin
              state      <= S_IDLE;
              o_done     <= 1'b1;
              o_position <= 32'h0000_0000;
            end else if (zp_rise) begin
              zcnt <= zcnt + 32'h0000_0001;
            end
          end
          // Second pass of mode 2: run back until the switch is seen again, then leave it.
          S_BACK: begin
            if (reference_switch_input) begin
              state <= S_EXIT;
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // reference_seek_motion_control

/* verification/seek_rules_properties.sv */
`include "seek_consts.vh"

// Watches the register port and status pins of the seek controller.
module seek_rules_checker (
  // Clock and reset.
  input wire        i_clk,
  input wire        i_sys_rst,
  // Register port.
  input wire [7:0]  i_addr,
  input wire [31:0] i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [31:0] o_rdata,
  // Motion and status.
  input wire        o_step,
  input wire        o_dir,
  input wire        o_done,
  input wire        o_busy,
  input wire [7:0]  o_error,
  input wire [31:0] o_position,
  input wire [31:0] o_speed
);
  timeunit 1ns;
  timeprecision 1ps;
  reg  enabled;
  wire cmd_wr;
  // A command counts only when taken while idle; busy writes are dropped.
  assign cmd_wr = i_wr && (i_addr == `REG_CMD) && !o_busy;
  // Mirror of the enable bit, so that command outcomes can be predicted.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      enabled <= 1'b0;
    end else if (i_wr && (i_addr == `REG_CTRL)) begin
      enabled <= i_wdata[`CTRL_ENABLE_BIT];
    end
  end
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  done_low_busy_a: assert property (o_busy |-> !o_done)
    else $error("done high while busy");
  done_on_finish_a: assert property ($fell(o_busy) && enabled |-> ##[0:1] o_done)
    else $error("done missing at end of seek");
  abort_on_drop_a: assert property (i_wr && i_addr == `REG_CTRL && !i_wdata[0] && o_busy
    |-> ##[1:3] (!o_busy && o_error == `ERR_ABORT)) else $error("seek not aborted");
  speed_at_rest_a: assert property (!o_busy ##1 !o_busy |-> o_speed == 32'h0)
    else $error("speed nonzero at rest");
  no_idle_step_a: assert property ((!o_busy)[*2] |-> !o_step)
    else $error("step while idle");
  not_enabled_a: assert property (cmd_wr && !enabled |=> o_error == `ERR_NOT_EN && o_done && !o_busy)
    else $error("command taken while disabled");
  bad_cmd_a: assert property (cmd_wr && enabled && i_wdata[7:0] != `CMD_SEEK && i_wdata[7:0] != `CMD_LOAD
    |=> o_error == `ERR_BAD_CMD && o_done) else $error("unknown command not flagged");
  load_done_a: assert property (cmd_wr && enabled && i_wdata[7:0] == `CMD_LOAD
    |=> o_done && o_error == `ERR_NONE && !o_busy) else $error("load not completed");
  pos_read_a: assert property (i_rd && i_addr == `REG_POS |=> o_rdata == $past(o_position))
    else $error("position read mismatch");
  status_read_a: assert property (i_rd && i_addr == `REG_STATUS
    |=> o_rdata[15:8] == $past(o_error) && o_rdata[2] == $past(o_dir)) else $error("status read mismatch");
  // Main endings of a seek.
  cover property ($fell(o_busy) && o_error == `ERR_NONE);
  cover property ($fell(o_busy) && o_error == `ERR_ABORT);
  cover property ($fell(o_busy) && o_error == `ERR_SHORT);
endmodule // seek_rules_checker

bind reference_seek_motion_control seek_rules_checker u_rules (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_step(o_step), .o_dir(o_dir),
  .o_done(o_done), .o_busy(o_busy), .o_error(o_error), .o_position(o_position), .o_speed(o_speed)
);

/* verification/axis_model.sv */
// Axis mechanics: a carriage moved by step pulses past a switch, a pulse track and two limits.
module axis_model #(
  parameter int REGION_LO = 21,
  parameter int REGION_HI = 38,
  parameter int LIMIT_TOP = 70
) (
  // Clock and motor drive.
  input  wire logic        i_clk,
  input  wire logic        i_step,
  input  wire logic        i_dir,
  // Carriage placement by the bench.
  input  wire logic        i_place,
  input  wire logic [31:0] i_place_pos,
  // Sensor levels and carriage place.
  output logic             o_reference_switch_input,
  output logic             o_zero_pulse_input,
  output logic             o_upper_limit_switch,
  output logic             o_lower_limit_switch,
  output int               o_pos
);
  timeunit 1ns;
  timeprecision 1ps;
  // Each step pulse moves the carriage by one in the commanded direction.
  always @(posedge i_clk) begin
    if (i_place) begin
      o_pos <= i_place_pos;
    end else if (i_step) begin
      o_pos <= i_dir ? o_pos + 1 : o_pos - 1;
    end
  end
  // Sensors depend on place only; the pulse track repeats every eight steps, off the switch edges.
  assign o_reference_switch_input = (o_pos >= REGION_LO) && (o_pos <= REGION_HI);
  assign o_zero_pulse_input       = (o_pos % 8) == 0;
  assign o_upper_limit_switch     = o_pos >= LIMIT_TOP;
  assign o_lower_limit_switch     = o_pos <= 0;
endmodule // axis_model

/* verification/reference_seek_motion_control_bench.sv */
`include "seek_consts.vh"

`define CHECK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
  $display("BAD %s expected %0h seen %0h", what, exp, got); end end

// Host side: register tasks and seek scenarios against the axis model.
module reference_seek_motion_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Fast seek is one step in ten clocks, slow one in twenty, to keep runs short.
  localparam logic [31:0] FAST = 32'h017d_7840;
  localparam logic [31:0] SLOW = 32'h00be_bc20;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        place = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [31:0] o_rdata, o_position, o_speed, rd_val;
  logic        rsw, zp, lim_up, lim_dn, o_step, o_dir, o_done, o_busy;
  logic [7:0]  o_error;
  int          fails = 0;
  int          samples_checked = 0;
  int          axis_pos;
  logic [7:0]  cfg_addr [5] = '{`REG_CFG_MODE, `REG_CFG_FAST, `REG_CFG_SLOW, `REG_CFG_ZCNT, `REG_CFG_DECEL};
  logic [31:0] cfg_rst [5] = '{`RST_CFG_MODE, `RST_CFG_FAST, `RST_CFG_SLOW, `RST_CFG_ZCNT, `RST_CFG_DECEL};

  reference_seek_motion_control dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_reference_switch_input(rsw), .i_zero_pulse_input(zp),
    .i_upper_limit_switch(lim_up), .i_lower_limit_switch(lim_dn), .o_step(o_step), .o_dir(o_dir),
    .o_done(o_done), .o_busy(o_busy), .o_error(o_error), .o_position(o_position), .o_speed(o_speed));
  // The bench parks the carriage at 50, on the work side for a positive approach.
  axis_model axis (
    .i_clk(i_clk), .i_step(o_step), .i_dir(o_dir), .i_place(place), .i_place_pos(32'h0000_0032),
    .o_reference_switch_input(rsw), .o_zero_pulse_input(zp), .o_upper_limit_switch(lim_up),
    .o_lower_limit_switch(lim_dn), .o_pos(axis_pos));

  // Free-running system clock.
  always #2 i_clk = ~i_clk;

  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so it is taken there.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic results;
    $display("Comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Bounded wait for the seek to finish; a hang ends the run.
  task automatic wait_idle;
    int n;
    n = 0;
    while (o_busy !== 1'b0 && n < 40000) begin
      @(posedge i_clk);
      #1 n++;
    end
    if (n >= 40000) begin
      fails++;
      $display("BAD wait_idle expected 0 seen 1");
      results();
    end
  endtask

  // Only one command is in flight; a new one starts only after the last went idle.
  task automatic start(input logic [31:0] mode, input logic load);
    wr(`REG_CFG_MODE, mode);
    if (load) wr(`REG_CMD, {24'h0, `CMD_LOAD});
    @(posedge i_clk);
    place <= 1'b1;
    @(posedge i_clk);
    place <= 1'b0;
    wr(`REG_CMD, {24'h0, `CMD_SEEK});
    #1;
    `CHECK("busy at start", 1'b1, o_busy)
    `CHECK("done at start", 1'b0, o_done)
  endtask

  task automatic seek(input logic [31:0] mode, input logic load, input int lo, input int hi, input logic [7:0] err);
    int n;
    start(mode, load);
    repeat (30) @(posedge i_clk);
    #1;
    `CHECK("fast speed", FAST, o_speed)
    // The fast phase ends when braking is over; the next speed shown must be the slow one.
    n = 0;
    while (o_speed === FAST && n < 40000) begin
      @(posedge i_clk);
      #1 n++;
    end
    if (err == `ERR_NONE) begin
      `CHECK("slow speed", SLOW, o_speed)
    end
    wait_idle();
    `CHECK("done", 1'b1, o_done)
    `CHECK("error", err, o_error)
    if (err == `ERR_NONE) begin
      `CHECK("stop place", 1'b1, (axis_pos >= lo && axis_pos <= hi))
      `CHECK("position", 32'h0, o_position)
    end
  endtask

  // Main sequence.
  initial begin
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      rd(cfg_addr[k], rd_val);
      `CHECK("table reset", cfg_rst[k], rd_val)
    end
    rd(8'h30, rd_val);
    `CHECK("unmapped read", 32'h0, rd_val)
    wr(`REG_CMD, {24'h0, `CMD_SEEK});
    #1 `CHECK("not enabled", `ERR_NOT_EN, o_error)
    wr(`REG_CTRL, 32'h1);
    wr(`REG_CFG_FAST, FAST);
    wr(`REG_CFG_SLOW, SLOW);
    wr(`REG_CFG_ZCNT, 32'h2);
    wr(`REG_CFG_DECEL, 32'h4);
    for (int k = 0; k < 4; k++) begin
      seek({26'h0, k[1:0], 4'h1}, 1'b1, k[1] ? 21 : 38, k[1] ? 21 : 38, `ERR_NONE);
    end
    seek(32'h22, 1'b1, 29, 30, `ERR_NONE);
    seek(32'h23, 1'b1, 48, 48, `ERR_NONE);
    seek(32'h24, 1'b1, 32, 32, `ERR_NONE);
    seek(32'h21, 1'b0, 32, 32, `ERR_NONE);
    rd(`REG_SPEED, rd_val);
    `CHECK("speed read", 32'h0, rd_val)
    rd(`REG_STATUS, rd_val);
    `CHECK("status done", 2'b01, rd_val[1:0])
    rd(`REG_POS, rd_val);
    `CHECK("position read", 32'h0, rd_val)
    wr(`REG_CMD, 32'h7);
    #1 `CHECK("bad command", `ERR_BAD_CMD, o_error)
    // Mode 0 ends at once without motion and clears the previous result.
    wr(`REG_CFG_MODE, 32'h20);
    wr(`REG_CMD, {24'h0, `CMD_LOAD});
    wr(`REG_CMD, {24'h0, `CMD_SEEK});
    #1 `CHECK("mode 0 idle", 1'b0, o_busy)
    `CHECK("mode 0 result", `ERR_NONE, o_error)
    start(32'h21, 1'b1);
    repeat (40) @(posedge i_clk);
    wr(`REG_CTRL, 32'h0);
    repeat (3) @(posedge i_clk);
    #1 `CHECK("abort busy", 1'b0, o_busy)
    `CHECK("abort code", `ERR_ABORT, o_error)
    wr(`REG_CTRL, 32'h1);
    wr(`REG_CFG_DECEL, 32'h1e);
    seek(32'h21, 1'b1, 0, 0, `ERR_SHORT);
    results();
  end
endmodule // reference_seek_motion_control_bench
